/* adc_alternating_mux_sequencer_tb_top.sv */
`timescale 1ns/100ps
module adc_alternating_mux_sequencer_tb_top;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, conv_start, irq;
  logic [11:0] conv_data;
  logic [19:0] sh_pos_sel, sh_neg_sel;
  logic [3:0] sh_sample, conv_chan;
  int err_total = 0;
  int compares = 0;
  // Hold codes: set A ch0, ch1, set B ch0, ch1
  logic [9:0] tbl [4] = '{10'h030, 10'h010, 10'h1f0, 10'h069};
  // Clock
  always #2.5 sys_clk = ~sys_clk;
  ams_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_data(conv_data), .sh_pos_sel(sh_pos_sel),
    .sh_neg_sel(sh_neg_sel), .sh_sample(sh_sample), .conv_chan(conv_chan),
    .conv_start(conv_start), .irq(irq));
  ams_conv_model u_conv (.sys_clk(sys_clk), .sh_pos_sel(sh_pos_sel),
    .sh_neg_sel(sh_neg_sel), .sh_sample(sh_sample), .conv_chan(conv_chan),
    .conv_data(conv_data));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do
      @(posedge sys_clk);
    while (pready !== 1'h1 && ++n < 40);
    if (pready !== 1'h1)
    begin
      err_total++;
      $display("unexpected %0t: bus wait timed out", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do
      @(posedge sys_clk);
    while (irq !== 1'h1 && ++n < 3000);
    if (irq !== 1'h1)
    begin
      err_total++;
      $display("unexpected %0t: interrupt wait timed out", $time);
    end
  endtask
  task automatic t_alt_split();
    apb(1'h1, 12'h004, 32'h01);
    apb(1'h1, 12'h008, 32'hef);
    apb(1'h1, 12'h014, 32'h1);
    apb(1'h1, 12'h000, 32'h13d3);
    for (int h = 0; h < 2; h++)
    begin
      wait_irq();
      apb(1'h0, 12'h010, 32'h0);
      cmp(rd & 32'hfd, h ? 32'h01 : 32'ha1);
      for (int i = 0; i < 8; i++)
      begin
        apb(1'h0, 12'h040 + 12'(h * 32 + i * 4), 32'h0);
        cmp(rd, {20'h0, tbl[i % 4], 1'h0, i[0]});
      end
      apb(1'h1, 12'h010, 32'h1);
      repeat (2) @(posedge sys_clk);
      cmp({31'h0, irq}, 32'h0);
    end
    apb(1'h1, 12'h000, 32'h0);
  endtask
  task automatic t_unmapped();
    apb(1'h0, 12'h020, 32'h0);
    cmp({er, rd[30:0]}, 32'h80000000);
    apb(1'h1, 12'h040, 32'hfff);
    apb(1'h0, 12'h040, 32'h0);
    cmp(rd, {20'h0, tbl[0], 2'h0});
  endtask
  task automatic t_manual();
    apb(1'h1, 12'h014, 32'h0);
    apb(1'h1, 12'h010, 32'h1);
    apb(1'h1, 12'h000, 32'h1450);
    repeat (100) @(posedge sys_clk);
    apb(1'h0, 12'h010, 32'h0);
    cmp({rd[0], 30'h0, irq}, 32'h80000000);
    apb(1'h1, 12'h010, 32'h1);
    repeat (100) @(posedge sys_clk);
    apb(1'h0, 12'h010, 32'h0);
    cmp(rd & 32'h3, 32'h0);
    apb(1'h1, 12'h014, 32'h1);
    apb(1'h1, 12'h000, 32'h1450);
    wait_irq();
    cmp({31'h0, irq}, 32'h1);
  endtask
  task automatic conclude();
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_alt_split();
    t_unmapped();
    t_manual();
    conclude();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
bind ams_sequencer ams_sequencer_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .sh_sample(sh_sample), .conv_chan(conv_chan),
  .conv_start(conv_start), .irq(irq));

/* ams_chan_route.v */
`timescale 1ns/100ps
`include "ams_defs.vh"
// Maps one set of input selections onto the four sample-hold inputs
module ams_chan_route (
  input wire [7:0] mux_set,
  input wire [3:0] scan_input,
  input wire scan_on,
  output reg [19:0] pos_sel,
  output reg [19:0] neg_sel
);
  integer i;
  // Code 5'h10 means the negative reference
  always @*
  begin
    pos_sel = 20'h00000;
    neg_sel = 20'h00000;
    // Primary positive: fixed set input unless scanning
    pos_sel[4:0] = scan_on ? {1'b0, scan_input} : {1'b0, mux_set[3:0]};
    // Primary negative: reference or input 1
    neg_sel[4:0] = mux_set[`AMS_MUX_NEG] ? 5'h01 : `AMS_IN_VREFN;
    for (i = 1; i < 4; i = i + 1)
    begin
      // Upper channel positive inputs 0..2 or 3..5
      pos_sel[i*5 +: 5] = mux_set[`AMS_MUX_UPOS] ? i[4:0] + 5'h02 : i[4:0] - 5'h01;
      case (mux_set[7:6])
        2'b10: neg_sel[i*5 +: 5] = i[4:0] + 5'h05;
        2'b11: neg_sel[i*5 +: 5] = i[4:0] + 5'h08;
        default: neg_sel[i*5 +: 5] = `AMS_IN_VREFN;
      endcase
    end
  end
endmodule

/* ams_conv_model.sv */
`timescale 1ns/100ps
module ams_conv_model (
  input wire sys_clk,
  input wire [19:0] sh_pos_sel,
  input wire [19:0] sh_neg_sel,
  input wire [3:0] sh_sample,
  input wire [3:0] conv_chan,
  output logic [11:0] conv_data
);
  logic [9:0] held_r [4];
  logic [11:0] last_r = 12'h000;
  // Each hold keeps its input codes from the end of tracking
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
      if (sh_sample[i])
        held_r[i] <= {sh_pos_sel[i*5 +: 5], sh_neg_sel[i*5 +: 5]};
    if (|conv_chan)
      last_r <= conv_data;
  end
  // Result names the held codes and the hold; idle output is junk
  always_comb
  begin
    conv_data = ~last_r;
    for (int i = 0; i < 4; i++)
      if (conv_chan[i])
        conv_data = {held_r[i], i[1:0]};
  end
endmodule

/* ams_defs.vh */
`ifndef AMS_DEFS_VH
`define AMS_DEFS_VH
// Register byte offsets
`define AMS_OFF_CTRL 12'h000
`define AMS_OFF_MUXA 12'h004
`define AMS_OFF_MUXB 12'h008
`define AMS_OFF_SCAN 12'h00c
`define AMS_OFF_STAT 12'h010
`define AMS_OFF_MASK 12'h014
`define AMS_OFF_BUF 12'h040
// Control field positions
`define AMS_CTL_SAMPLES_PER_IRQ_FIELD_LO 0
`define AMS_CTL_CHANNEL_COUNT_FIELD_LO 4
`define AMS_CTL_SIMULTANEOUS_SAMPLE_SEL 6
`define AMS_CTL_SPLIT_BUFFER_SEL 7
`define AMS_CTL_ALTERNATE_INPUT_SEL 8
`define AMS_CTL_AUTO_SAMPLE_ENABLE 9
`define AMS_CTL_SAMP 10
`define AMS_CTL_SCAN 11
`define AMS_CTL_ON 12
// Mux set fields
`define AMS_MUX_POS_LO 0
`define AMS_MUX_NEG 4
`define AMS_MUX_UPOS 5
`define AMS_MUX_UNEG_LO 6
// Reset values
`define AMS_CTRL_RST 13'h0000
`define AMS_MUX_RST 8'h00
// Timing counts in converter cycles
`define AMS_SAMP_CYC 4'h3
`define AMS_CONV_CYC 4'hc
// Input codes
`define AMS_IN_VREFN 5'h10
`endif

/* ams_sequencer.v */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "ams_defs.vh"
module ams_sequencer (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [11:0] conv_data,
  output reg [19:0] sh_pos_sel,
  output reg [19:0] sh_neg_sel,
  output reg [3:0] sh_sample,
  output reg [3:0] conv_chan,
  output reg conv_start,
  output reg irq
);
  // One-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMP = 3'b010;
  localparam ST_CONV = 3'b100;

  // Software-visible configuration
  reg [12:0] ctrl_r;
  reg [7:0] muxa_r;
  reg [7:0] muxb_r;
  reg [15:0] scan_mask_r;
  reg status_r;
  reg mask_r;
  // Sequencer state
  reg [2:0] state_r;
  reg [3:0] tmr_r;
  reg [1:0] chan_r;
  reg [3:0] wr_ptr_r;
  reg [3:0] seq_cnt_r;
  reg set_b_r;
  reg half_r;
  reg [3:0] scan_idx_r;
  // Decoded controls and datapath
  wire [19:0] pos_w;
  wire [19:0] neg_w;
  wire [1:0] last_chan;
  wire [3:0] samples_per_irq_field;
  wire wr_acc;
  wire rd_acc;
  wire [11:0] buf_sel;
  wire [191:0] buf_flat;
  wire buf_we;
  wire [15:0] buf_wr_oh;
  wire seq_end;
  wire irq_evt;
  wire [3:0] scan_input;
  reg [31:0] rdata_nxt;
  reg addr_ok;

  assign samples_per_irq_field = ctrl_r[`AMS_CTL_SAMPLES_PER_IRQ_FIELD_LO +: 4];
  assign wr_acc = psel & penable & pwrite & clk_en;
  assign rd_acc = psel & penable & ~pwrite & clk_en;
  // Channel count: 00 one, 01 two, 1x four
  assign last_chan = ctrl_r[`AMS_CTL_CHANNEL_COUNT_FIELD_LO + 1] ? 2'd3 :
                     (ctrl_r[`AMS_CTL_CHANNEL_COUNT_FIELD_LO] ? 2'd1 : 2'd0);
  assign seq_end = (state_r == ST_CONV) && (tmr_r == 4'h0) && (chan_r == last_chan);
  assign irq_evt = seq_end && (seq_cnt_r == samples_per_irq_field);
  assign buf_sel = buf_flat[paddr[5:2] * 12 +: 12];
  // A result lands at the last cycle of each conversion
  assign buf_we = (state_r == ST_CONV) && (tmr_r == 4'h0);
  assign buf_wr_oh = buf_we ? (16'h0001 << wr_ptr_r) : 16'h0000;
  assign scan_input = scan_idx_r;

  // Route the active input set
  ams_chan_route u_route (
    .mux_set(set_b_r ? muxb_r : muxa_r),
    .scan_input(scan_input),
    .scan_on(ctrl_r[`AMS_CTL_SCAN]),
    .pos_sel(pos_w),
    .neg_sel(neg_w)
  );

  // Result words: each entry loads only when the write pointer names it
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_buf
      reg [11:0] word_r;
      always @(posedge sys_clk)
      begin
        if (clk_en && buf_wr_oh[g])
          word_r <= conv_data;
      end
      assign buf_flat[g * 12 +: 12] = word_r;
    end
  endgenerate

  // Read mux and address decode
  always @*
  begin
    rdata_nxt = 32'h00000000;
    addr_ok = 1'b1;
    if (paddr >= `AMS_OFF_BUF && paddr < `AMS_OFF_BUF + 12'h040)
      rdata_nxt = {20'h00000, buf_sel};
    else
      case (paddr)
        `AMS_OFF_CTRL: rdata_nxt = {19'h00000, ctrl_r};
        `AMS_OFF_MUXA: rdata_nxt = {24'h000000, muxa_r};
        `AMS_OFF_MUXB: rdata_nxt = {24'h000000, muxb_r};
        `AMS_OFF_SCAN: rdata_nxt = {16'h0000, scan_mask_r};
        `AMS_OFF_STAT: rdata_nxt = {24'h000000, half_r, set_b_r, wr_ptr_r, state_r == ST_IDLE ? 1'b0 : 1'b1, status_r};
        `AMS_OFF_MASK: rdata_nxt = {31'h00000000, mask_r};
        default: addr_ok = 1'b0;
      endcase
  end

  // APB response: one wait state, ready in access phase
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (rd_acc & ~pready)
        prdata <= rdata_nxt;
    end
  end

  // Sticky flag: set wins over write-one-to-clear
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      status_r <= 1'b0;
    else if (clk_en)
    begin
      if (irq_evt)
        status_r <= 1'b1;
      else if (wr_acc && pready && paddr == `AMS_OFF_STAT && pwdata[0])
        status_r <= 1'b0;
    end
  end

  // Registered route codes and interrupt level
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
      sh_pos_sel <= 20'h00000;
      sh_neg_sel <= 20'h00000;
    end
    else if (clk_en)
    begin
      sh_pos_sel <= pos_w;
      sh_neg_sel <= neg_w;
      irq <= status_r & mask_r;
    end
  end

  // Configuration and sequencer
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `AMS_CTRL_RST;
      muxa_r <= `AMS_MUX_RST;
      muxb_r <= `AMS_MUX_RST;
      scan_mask_r <= 16'h0000;
      mask_r <= 1'b0;
      state_r <= ST_IDLE;
      tmr_r <= 4'h0;
      chan_r <= 2'd0;
      wr_ptr_r <= 4'h0;
      seq_cnt_r <= 4'h0;
      set_b_r <= 1'b0;
      half_r <= 1'b0;
      scan_idx_r <= 4'h0;
      sh_sample <= 4'h0;
      conv_start <= 1'b0;
      conv_chan <= 4'h0;
    end
    else if (clk_en)
    begin
      conv_start <= 1'b0;
      // Register writes take effect when pready is sampled high
      if (wr_acc && pready && !pslverr)
        case (paddr)
          `AMS_OFF_CTRL: ctrl_r <= pwdata[12:0];
          `AMS_OFF_MUXA: muxa_r <= pwdata[7:0];
          `AMS_OFF_MUXB: muxb_r <= pwdata[7:0];
          `AMS_OFF_SCAN: scan_mask_r <= pwdata[15:0];
          `AMS_OFF_MASK: mask_r <= pwdata[0];
          default: ;
        endcase
      case (state_r)
        ST_IDLE:
        begin
          // Wait for a software or automatic start
          if (ctrl_r[`AMS_CTL_ON] && (ctrl_r[`AMS_CTL_SAMP] || ctrl_r[`AMS_CTL_AUTO_SAMPLE_ENABLE]))
          begin
            state_r <= ST_SAMP;
            tmr_r <= `AMS_SAMP_CYC;
            ctrl_r[`AMS_CTL_SAMP] <= 1'b0;
            // Simultaneous: all enabled holds track together
            if (ctrl_r[`AMS_CTL_SIMULTANEOUS_SAMPLE_SEL])
              sh_sample <= (4'h1 << last_chan) - 4'h1 | (4'h1 << last_chan);
            else
              sh_sample <= 4'h1;
          end
          else if (!ctrl_r[`AMS_CTL_ON])
          begin
            // Switched off: the next run starts afresh at location zero, set A
            seq_cnt_r <= 4'h0;
            wr_ptr_r <= 4'h0;
            half_r <= 1'b0;
            set_b_r <= 1'b0;
          end
        end
        ST_SAMP:
        begin
          // Tracking window, then the primary conversion starts
          if (tmr_r == 4'h0)
          begin
            sh_sample <= 4'h0;
            state_r <= ST_CONV;
            tmr_r <= `AMS_CONV_CYC;
            chan_r <= 2'd0;
            conv_chan <= 4'h1;
            conv_start <= 1'b1;
          end
          else
            tmr_r <= tmr_r - 4'h1;
        end
        ST_CONV:
        begin
          // One conversion per enabled hold
          if (tmr_r != 4'h0)
            tmr_r <= tmr_r - 4'h1;
          else
          begin
            wr_ptr_r <= wr_ptr_r + 4'h1;
            if (chan_r != last_chan)
            begin
              // Next hold in ascending order
              chan_r <= chan_r + 2'd1;
              conv_chan <= conv_chan << 1;
              conv_start <= 1'b1;
              tmr_r <= `AMS_CONV_CYC;
              if (!ctrl_r[`AMS_CTL_SIMULTANEOUS_SAMPLE_SEL])
                sh_sample <= conv_chan << 1;
            end
            else
            begin
              // Last hold done: close the sequence
              conv_chan <= 4'h0;
              state_r <= ST_IDLE;
              set_b_r <= ctrl_r[`AMS_CTL_ALTERNATE_INPUT_SEL] ? ~set_b_r : 1'b0;
              if (ctrl_r[`AMS_CTL_SCAN])
                scan_idx_r <= scan_idx_r + 4'h1;
              if (irq_evt)
              begin
                seq_cnt_r <= 4'h0;
                half_r <= ~half_r;
                // Split mode swaps halves; single mode restarts at zero
                if (ctrl_r[`AMS_CTL_SPLIT_BUFFER_SEL])
                  wr_ptr_r <= {~half_r, 3'h0};
                else
                  wr_ptr_r <= 4'h0;
              end
              else
                seq_cnt_r <= seq_cnt_r + 4'h1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

/* ams_sequencer_monitor.sv */
`timescale 1ns/100ps
module ams_sequencer_monitor (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [3:0] sh_sample,
  input wire [3:0] conv_chan,
  input wire conv_start,
  input wire irq
);
  reg [12:0] ctrl_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the control word as software last wrote it
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      ctrl_r <= 13'h0000;
    else if (psel && penable && pwrite && pready && paddr == 12'h000)
      ctrl_r <= pwdata[12:0];
  end
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_ready; pslverr |-> pready && psel; endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  property p_hold_idle; |conv_chan |-> sh_sample == 4'h0; endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("sampling in conversion");
  property p_onehot; $onehot0(conv_chan); endproperty
  a_onehot: assert property (p_onehot) else $error("two channels converting");
  property p_start;
    conv_start |-> $onehot(conv_chan) && conv_chan != $past(conv_chan) ##1 !conv_start;
  endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  property p_ascend;
    ctrl_r[6] && |conv_chan && |$past(conv_chan) && conv_chan != $past(conv_chan)
      |-> conv_chan == ($past(conv_chan) << 1);
  endproperty
  a_ascend: assert property (p_ascend) else $error("channel order");
  property p_two_chan; ctrl_r[5:4] == 2'h1 |-> (conv_chan | sh_sample) < 4'h4; endproperty
  a_two_chan: assert property (p_two_chan) else $error("upper hold used");
  property p_simul; ctrl_r[6] && ctrl_r[5:4] == 2'h1 |-> sh_sample[0] == sh_sample[1]; endproperty
  a_simul: assert property (p_simul) else $error("holds not together");
  property p_restart;
    ctrl_r[12] && ctrl_r[9] && ctrl_r[6] && ctrl_r[5:4] == 2'h1 && $fell(conv_chan[1])
      |-> ##[0:8] sh_sample[0];
  endproperty
  a_restart: assert property (p_restart) else $error("no auto restart");
  property p_irq_keep; irq && !psel && !$past(psel) |=> irq; endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("irq dropped alone");
  c_irq: cover property ($rose(irq));
  c_second: cover property (conv_chan[1]);
  c_err: cover property (pslverr);
endmodule
